// file: dv/logic_bit_exec_tb_top.sv
// Self-checking bench for the logic and bit-operation executor.
// Assumes clk_en held high; banking stays off except in the one banked scenario.
`timescale 1ns/100ps
module logic_bit_exec_tb_top;
  import logic_bit_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        clk_en = 1'b1;
  logic        memory_bank_enable = 1'b0;
  logic [3:0]  bank_sel = 4'h0;
  logic        preset_we = 1'b0;
  logic [1:0]  preset_sel = 2'h0;
  logic [7:0]  preset_val = 8'h00;
  logic        preset_carry = 1'b0;
  logic [7:0]  prog_byte;
  logic [3:0]  dm_rdata;
  logic [11:0] prog_addr, dm_addr;
  logic        dm_we, carry, instr_done, skip_taken, bad_op;
  logic [3:0]  dm_wdata;
  logic [7:0]  extended_accumulator, pointer_pair, pair_wx, pair_yz;
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          first_we, first_done, first_bad, we_cnt, skip_cnt;
  logic        carry_log [$];

  logic_bit_exec dut (.clock(clock), .rstn(rstn), .clk_en(clk_en), .prog_byte(prog_byte),
    .dm_rdata(dm_rdata), .memory_bank_enable(memory_bank_enable), .bank_sel(bank_sel),
    .preset_we(preset_we), .preset_sel(preset_sel), .preset_val(preset_val),
    .preset_carry(preset_carry), .prog_addr(prog_addr), .dm_addr(dm_addr), .dm_we(dm_we),
    .dm_wdata(dm_wdata), .extended_accumulator(extended_accumulator),
    .pointer_pair(pointer_pair), .pair_wx(pair_wx), .pair_yz(pair_yz), .carry(carry),
    .instr_done(instr_done), .skip_taken(skip_taken), .bad_op(bad_op));

  mem_model mem (.clock(clock), .prog_addr(prog_addr), .prog_byte(prog_byte),
    .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_we(dm_we), .dm_wdata(dm_wdata));

  always #20 clock = ~clock;

  // ==========================================
  // Helpers
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Two one-byte fillers at 0 and 1 give four edges for loading the pairs
  task automatic load(input logic [7:0] b [$]);
    for (int i = 0; i < 64; i++) begin
      mem.prog_mem[i] = (i >= 2 && i - 2 < b.size()) ? b[i-2] : 8'h00;
    end
    for (int i = 0; i < 4096; i++) begin
      mem.data_mem[i] = 4'h0;
    end
  endtask

  task automatic run(input logic [7:0] acc_v, ptr_v, wx_v, input logic c, input int n);
    logic [7:0] v [4];
    v = '{acc_v, ptr_v, wx_v, ~wx_v};
    first_we = -1;
    first_done = -1;
    first_bad = -1;
    we_cnt = 0;
    skip_cnt = 0;
    carry_log.delete();
    rstn = 1'b0;
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < n; i++) begin
      preset_we = (i < 4);
      preset_sel = 2'(i);
      preset_val = v[i%4];
      preset_carry = c;
      @(posedge clock);
      @(negedge clock);
      if (dm_we === 1'b1) begin
        we_cnt++;
        if (first_we < 0) first_we = i;
      end
      if (skip_taken === 1'b1) skip_cnt++;
      // Fillers at 0 and 1 are unhandled on purpose; only later ones count
      if (bad_op === 1'b1 && i >= 4 && first_bad < 0) first_bad = i;
      if (instr_done === 1'b1 && bad_op !== 1'b1) begin
        carry_log.push_back(carry);
        if (first_done < 0) first_done = i;
      end
    end
    preset_we = 1'b0;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_and_forms;
    load('{8'hdd, 8'h1a});
    run(8'h5c, 8'h00, 8'h00, 1'b0, 12);
    chk("acc imm", 12'h058, {4'h0, extended_accumulator});
    chk("done imm", 12'd7, 12'(first_done));
    load('{8'h39});
    mem.data_mem[12'h029] = 4'h6;
    run(8'h0c, 8'h29, 8'h00, 1'b0, 10);
    chk("acc ptr", 12'h004, {4'h0, extended_accumulator});
    chk("src ptr", 12'h006, {8'h0, mem.data_mem[12'h029]});
    chk("done ptr", 12'd5, 12'(first_done));
    load('{8'hdc, 8'h1a, 8'hdc, 8'h14, 8'hdc, 8'h16});
    run(8'hc3, 8'h55, 8'hf0, 1'b0, 18);
    chk("acc pair", 12'h041, {4'h0, extended_accumulator});
    chk("ptr pair", 12'h055, {4'h0, pointer_pair});
    chk("wx pair", 12'h040, {4'h0, pair_wx});
    chk("yz pair", 12'h001, {4'h0, pair_yz});
    chk("done pair", 12'd7, 12'(first_done));
    $display("test and_forms done");
  endtask

  task automatic t_bit_forms;
    load('{8'he1, 8'h30, 8'hd0, 8'h85, 8'hff, 8'hb5, 8'hfe, 8'hc2, 8'hfe, 8'h43, 8'hff, 8'h30});
    mem.data_mem[12'hf85] = 4'hf;
    mem.data_mem[12'hff2] = 4'hf;
    mem.data_mem[12'hfce] = 4'hf;
    mem.data_mem[12'h031] = 4'h5;
    run(8'h00, 8'h29, 8'h00, 1'b0, 30);
    chk("dir set", 12'h004, {8'h0, mem.data_mem[12'h030]});
    chk("neighbour", 12'h005, {8'h0, mem.data_mem[12'h031]});
    chk("dir clr", 12'h00d, {8'h0, mem.data_mem[12'hf85]});
    chk("short set", 12'h008, {8'h0, mem.data_mem[12'hfb5]});
    chk("short clr", 12'h00e, {8'h0, mem.data_mem[12'hff2]});
    chk("index clr", 12'h00d, {8'h0, mem.data_mem[12'hfce]});
    chk("paged set", 12'h008, {8'h0, mem.data_mem[12'h020]});
    chk("first write", 12'd7, 12'(first_we));
    chk("writes", 12'd6, 12'(we_cnt));
    $display("test bit_forms done");
  endtask

  task automatic t_carry_ops;
    logic e [4];
    e = '{1'b1, 1'b0, 1'b0, 1'b1};
    // Last pair has an unhandled second byte and must leave carry alone
    load('{8'hf5, 8'hb5, 8'hf5, 8'hc2, 8'hf6, 8'h30, 8'hf6, 8'h43, 8'hf6, 8'h53});
    mem.data_mem[12'hfb5] = 4'h8;
    mem.data_mem[12'hff2] = 4'he;
    mem.data_mem[12'hfce] = 4'h2;
    run(8'h00, 8'h29, 8'h00, 1'b1, 24);
    for (int i = 0; i < 4; i++) begin
      chk("carry step", {11'h0, e[i]}, {11'h0, carry_log[i]});
    end
    chk("steps", 12'd4, 12'(carry_log.size()));
    chk("done cand", 12'd7, 12'(first_done));
    chk("writes", 12'd0, 12'(we_cnt));
    chk("src bit", 12'h00e, {8'h0, mem.data_mem[12'hff2]});
    chk("bad seen", 12'd23, 12'(first_bad));
    chk("carry kept", 12'h001, {11'h0, carry});
    $display("test carry_ops done");
  endtask

  task automatic t_skip;
    load('{8'he2, 8'h30, 8'hff, 8'hb4, 8'hf8, 8'hb5, 8'hff, 8'hc2, 8'hf8, 8'h30, 8'h39});
    mem.data_mem[12'hfb5] = 4'h8;
    run(8'ha5, 8'h29, 8'h00, 1'b0, 28);
    chk("skipped set", 12'h000, {8'h0, mem.data_mem[12'hfb4]});
    chk("run set", 12'h001, {8'h0, mem.data_mem[12'hff2]});
    chk("tested bit", 12'h008, {8'h0, mem.data_mem[12'hfb5]});
    chk("skipped and", 12'h0a5, {4'h0, extended_accumulator});
    chk("skips", 12'd2, 12'(skip_cnt));
    chk("write time", 12'd19, 12'(first_we));
    chk("writes", 12'd1, 12'(we_cnt));
    chk("pc", 12'h00e, prog_addr);
    $display("test skip done");
  endtask

  task automatic t_adc_ads(input logic [3:0] a, v, input logic c_exp, input int s_exp);
    load('{8'h3e, 8'haa, 8'hff, 8'hb5});
    mem.data_mem[12'h029] = v;
    run({4'h0, a}, 8'h29, 8'h00, 1'b0, 16);
    chk("acc", 12'h007, {8'h0, extended_accumulator[3:0]});
    chk("carry", {11'h0, c_exp}, {11'h0, carry});
    chk("skips", 12'(s_exp), 12'(skip_cnt));
    chk("next ran", 12'h008, {8'h0, mem.data_mem[12'hfb5]});
    $display("test adc_ads done");
  endtask

  // Banking on: direct and pointer addresses both take bank_sel
  task automatic t_bank;
    load('{8'he1, 8'h85, 8'h39});
    mem.data_mem[12'h329] = 4'h6;
    memory_bank_enable = 1'b1;
    bank_sel = 4'h3;
    run(8'h0c, 8'h29, 8'h00, 1'b0, 12);
    memory_bank_enable = 1'b0;
    bank_sel = 4'h0;
    chk("bank set", 12'h004, {8'h0, mem.data_mem[12'h385]});
    chk("io untouched", 12'h000, {8'h0, mem.data_mem[12'hf85]});
    chk("bank and", 12'h004, {4'h0, extended_accumulator});
    $display("test bank done");
  endtask

  // ==========================================
  // Main sequence
  initial begin
    t_and_forms();
    t_bit_forms();
    t_carry_ops();
    t_skip();
    t_adc_ads(4'he, 4'h9, 1'b1, 1);
    t_adc_ads(4'h9, 4'h4, 1'b0, 0);
    t_bank();
    end_sim();
  end
endmodule

// file: dv/mem_model.sv
// Program and data memory standing behind the executor.
// Assumes the bench fills both arrays by hierarchical access before each run.
`timescale 1ns/100ps
module mem_model (
  input  wire logic        clock,
  input  wire logic [11:0] prog_addr,
  output logic      [7:0]  prog_byte,
  input  wire logic [11:0] dm_addr,
  output logic      [3:0]  dm_rdata,
  input  wire logic        dm_we,
  input  wire logic [3:0]  dm_wdata
);
  logic [7:0] prog_mem [4096];
  logic [3:0] data_mem [4096];

  // ==========================================
  // Reads
  assign prog_byte = prog_mem[prog_addr];
  assign dm_rdata  = data_mem[dm_addr];

  // ==========================================
  // Writes
  // Lands on the edge ending the strobe clock, as a real array would
  always @(posedge clock) begin
    if (dm_we === 1'b1) begin
      data_mem[dm_addr] <= dm_wdata;
    end
  end
endmodule

// file: hw/bit_addr_gen.sv
// Bit operand address former: nibble address and bit select from the two opcode bytes.
// Purely combinational; the executor registers its results before they reach any pin.
`timescale 1ns/100ps
module bit_addr_gen
  import logic_bit_pkg::*;
(
  input  wire logic [7:0]  first_byte,
  input  wire logic [7:0]  second_byte,
  input  wire logic [3:0]  ptr_h,
  input  wire logic [3:0]  ptr_l,
  input  wire logic        memory_bank_enable,
  input  wire logic [3:0]  bank_sel,
  output logic      [11:0] nib_addr,
  output logic      [1:0]  bit_sel,
  output logic             addr_ok
);
  logic direct;

  always_comb begin
    direct   = (first_byte[7:6] == TWO_BYTE_HI) && (first_byte[3:0] <= DIR_TEST);
    nib_addr = {BANK_ZERO, second_byte};
    bit_sel  = second_byte[5:4];
    addr_ok  = 1'b1;
    if (direct) begin
      bit_sel = first_byte[5:4];
      // Upper half of the page maps onto the I/O bank while banking is off
      if (memory_bank_enable) begin
        nib_addr = {bank_sel, second_byte};
      end else if (second_byte[7]) begin
        nib_addr = {BANK_IO, second_byte};
      end
    end else if (second_byte[7:6] == SB_SHORT_LO) begin
      nib_addr = {SHORT_LO_PAGE, second_byte[3:0]};
    end else if (second_byte[7:6] == SB_SHORT_HI) begin
      nib_addr = {SHORT_HI_PAGE, second_byte[3:0]};
    end else if (second_byte[7:6] == SB_PAGED) begin
      nib_addr = {BANK_ZERO, ptr_h, second_byte[3:0]};
    end else if (second_byte[5:4] == SB_INDEX_SUB) begin
      nib_addr = {BANK_IO, INDEX_TOP, second_byte[3:0], ptr_l[3:2]};
      bit_sel  = ptr_l[1:0];
    end else begin
      addr_ok = 1'b0;
    end
  end
endmodule

// file: hw/logic_bit_exec.sv
// Executor for logical AND, carry bit AND/OR, bit clear/set and test-skip-if-zero.
// Assumes program and data memories answer combinationally to the registered addresses.
// One machine cycle is two enabled clocks: phase 0 fetches, phase 1 executes.
`timescale 1ns/100ps

// Behaviour
// - AND writes source AND destination into destination, source left alone.
// - AND accumulator immediate: bytes 11011101, 0001 plus immediate; two cycles.
// - AND accumulator with pointer_pair nibble: one byte 00111001, one cycle.
// - Pair AND: 11011100, then 0001, direction, pair select, zero; two cycles.
// - Carry AND bit clears carry when the bit is zero, else keeps it.
// - Carry AND bit forms start 11110101, two bytes, two cycles.
// - Indexed form: 0100 plus a5..a2, L3-2 join address, L1-0 pick bit.
// - Paged form: 00, bit select, four address bits behind H.
// - Bit clear forces only the chosen bit to zero.
// - Bit clear: direct 11bb0000 plus address, others 11111110; two cycles.
// - Bit set forces only the chosen bit to one.
// - Bit set: direct 11bb0001 plus address, others 11111111; two cycles.
// - Carry OR bit: carry gets carry OR bit, byte 11110110, two cycles.
// - Test skips the next instruction when the bit is zero, bit untouched.
// - Test forms take two bytes, two cycles plus skip cycles.
// - Add-skip right after add-with-carry from memory makes no own skip.
// - Add-with-carry overflow skips a directly following add-skip immediate.
module logic_bit_exec
  import logic_bit_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  prog_byte,
  input  wire logic [3:0]  dm_rdata,
  input  wire logic        memory_bank_enable,
  input  wire logic [3:0]  bank_sel,
  input  wire logic        preset_we,
  input  wire logic [1:0]  preset_sel,
  input  wire logic [7:0]  preset_val,
  input  wire logic        preset_carry,
  output logic      [11:0] prog_addr,
  output logic      [11:0] dm_addr,
  output logic             dm_we,
  output logic      [3:0]  dm_wdata,
  output logic      [7:0]  extended_accumulator,
  output logic      [7:0]  pointer_pair,
  output logic      [7:0]  pair_wx,
  output logic      [7:0]  pair_yz,
  output logic             carry,
  output logic             instr_done,
  output logic             skip_taken,
  output logic             bad_op
);
  seq_state_t  st_r;
  exec_kind_t  kind;
  logic        phase_r;
  logic [11:0] pc_r;
  logic [7:0]  ir_r;
  logic [7:0]  op2_r;
  logic [1:0]  bit_sel_r;
  logic        addr_ok_r;
  logic        skip_len2_r;
  logic        after_adc_r;
  logic        adc_ovf_r;
  logic [7:0]  pair_r [4];
  logic        carry_r;
  logic [11:0] dm_addr_r;
  logic        dm_we_r;
  logic [3:0]  dm_wdata_r;
  logic        done_r;
  logic        skip_r;
  logic        bad_r;
  logic [11:0] gen_addr;
  logic [11:0] ptr_addr;
  logic [1:0]  gen_bit;
  logic        gen_ok;
  logic        exec;
  logic        bit_val;
  logic        two_byte;
  logic        skip_now;
  logic        discard_imm;
  logic [3:0]  acc;
  logic [3:0]  bit_mask;
  logic [7:0]  pair_src;
  logic [4:0]  adc_sum;
  logic [4:0]  imm_sum;

  // ==========================================================================
  // Operand forming
  bit_addr_gen u_addr (
    .first_byte         (ir_r),
    .second_byte        (prog_byte),
    .ptr_h              (pair_r[PAIR_PTR][7:4]),
    .ptr_l              (pair_r[PAIR_PTR][3:0]),
    .memory_bank_enable (memory_bank_enable),
    .bank_sel           (bank_sel),
    .nib_addr           (gen_addr),
    .bit_sel            (gen_bit),
    .addr_ok            (gen_ok)
  );

  assign exec     = clk_en & phase_r;
  assign acc      = pair_r[PAIR_ACC][3:0];
  assign pair_src = pair_r[op2_r[2:1]];
  assign ptr_addr = {memory_bank_enable ? bank_sel : BANK_ZERO, pair_r[PAIR_PTR]};
  assign bit_val  = dm_rdata[bit_sel_r];
  assign bit_mask = 4'h1 << bit_sel_r;
  assign two_byte = ir_r[7:6] == TWO_BYTE_HI;
  assign adc_sum  = {1'b0, acc} + {1'b0, dm_rdata} + {4'h0, carry_r};
  assign imm_sum  = {1'b0, acc} + {1'b0, ir_r[3:0]};

  // ==========================================================================
  // Decode of the instruction in its execute phase
  always_comb begin
    kind = K_NONE;
    if (st_r == ST_FIRST && !two_byte) begin
      if (ir_r == OP_AND_PTR) begin
        kind = K_AND_PTR;
      end else if (ir_r == OP_ADC_PTR) begin
        kind = K_ADC;
      end else if (ir_r[7:4] == ADD_SKIP_HI) begin
        kind = K_ADD_IMM;
      end else begin
        kind = K_BAD;
      end
    end else if (st_r == ST_SECOND) begin
      if (ir_r == OP_AND_IMM) begin
        kind = (op2_r[7:4] == AND_SUBCODE) ? K_AND_IMM : K_BAD;
      end else if (ir_r == OP_PAIR_PFX) begin
        if (op2_r[7:4] != AND_SUBCODE || op2_r[0]) begin
          kind = K_BAD;
        end else if (op2_r[3]) begin
          kind = K_AND_TO_ACC;
        end else begin
          kind = K_AND_TO_PAIR;
        end
      end else if (!addr_ok_r) begin
        kind = K_BAD;
      end else if (ir_r == OP_CARRY_AND) begin
        kind = K_CAND;
      end else if (ir_r == OP_CARRY_OR) begin
        kind = K_COR;
      end else if (ir_r == OP_TEST_ZERO || ir_r[3:0] == DIR_TEST) begin
        kind = K_TEST;
      end else if (ir_r == OP_BIT_CLR || ir_r[3:0] == DIR_CLR) begin
        kind = K_CLR;
      end else if (ir_r == OP_BIT_SET || ir_r[3:0] == DIR_SET) begin
        kind = K_SET;
      end else begin
        kind = K_BAD;
      end
    end
  end

  assign skip_now    = (kind == K_TEST && !bit_val)
                     || (kind == K_ADD_IMM && imm_sum[4] && !after_adc_r);
  assign discard_imm = kind == K_ADD_IMM && after_adc_r && adc_ovf_r;

  // ==========================================================================
  // Sequencer: one byte per machine cycle, skips included
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r        <= ST_FIRST;
      phase_r     <= 1'b0;
      pc_r        <= PC_RESET;
      ir_r        <= PAIR_RESET;
      op2_r       <= PAIR_RESET;
      bit_sel_r   <= 2'b00;
      addr_ok_r   <= 1'b0;
      skip_len2_r <= 1'b0;
      after_adc_r <= 1'b0;
      adc_ovf_r   <= 1'b0;
    end else if (clk_en) begin
      phase_r <= !phase_r;
      if (!phase_r) begin
        pc_r <= pc_r + 12'h001;
        case (st_r)
          ST_FIRST: begin
            ir_r <= prog_byte;
          end
          ST_SECOND: begin
            op2_r     <= prog_byte;
            bit_sel_r <= gen_bit;
            addr_ok_r <= gen_ok;
          end
          ST_SKIP1: begin
            // Only the prefix pattern is known here; length is inferred from it
            skip_len2_r <= prog_byte[7:6] == TWO_BYTE_HI;
          end
          default: begin
          end
        endcase
      end else begin
        case (st_r)
          ST_FIRST: begin
            if (two_byte) begin
              st_r <= ST_SECOND;
            end else begin
              st_r        <= skip_now ? ST_SKIP1 : ST_FIRST;
              after_adc_r <= kind == K_ADC;
              adc_ovf_r   <= adc_sum[4];
            end
          end
          ST_SECOND: begin
            st_r        <= skip_now ? ST_SKIP1 : ST_FIRST;
            after_adc_r <= 1'b0;
          end
          ST_SKIP1: begin
            st_r        <= skip_len2_r ? ST_SKIP2 : ST_FIRST;
            after_adc_r <= 1'b0;
          end
          default: begin
            st_r <= ST_FIRST;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Data memory port; a write issued in phase 1 lands at the end of phase 0
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dm_addr_r  <= PC_RESET;
      dm_we_r    <= 1'b0;
      dm_wdata_r <= 4'h0;
    end else if (clk_en) begin
      if (!phase_r) begin
        dm_we_r <= 1'b0;
        if (st_r == ST_FIRST) begin
          dm_addr_r <= ptr_addr;
        end else if (st_r == ST_SECOND) begin
          dm_addr_r <= gen_addr;
        end
      end else if (kind == K_CLR) begin
        dm_we_r    <= 1'b1;
        dm_wdata_r <= dm_rdata & ~bit_mask;
      end else if (kind == K_SET) begin
        dm_we_r    <= 1'b1;
        dm_wdata_r <= dm_rdata | bit_mask;
      end
    end
  end

  // ==========================================================================
  // Register pairs; the preset port stands in for the rest of the core
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        pair_r[i] <= PAIR_RESET;
      end
    end else if (clk_en) begin
      if (preset_we) begin
        pair_r[preset_sel] <= preset_val;
      end else if (exec) begin
        case (kind)
          K_AND_PTR:     pair_r[PAIR_ACC][3:0] <= acc & dm_rdata;
          K_AND_IMM:     pair_r[PAIR_ACC][3:0] <= acc & op2_r[3:0];
          K_AND_TO_ACC:  pair_r[PAIR_ACC] <= pair_r[PAIR_ACC] & pair_src;
          K_AND_TO_PAIR: pair_r[op2_r[2:1]] <= pair_src & pair_r[PAIR_ACC];
          K_ADC:         pair_r[PAIR_ACC][3:0] <= adc_sum[3:0];
          K_ADD_IMM: begin
            if (!discard_imm) begin
              pair_r[PAIR_ACC][3:0] <= imm_sum[3:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Carry flag
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      carry_r <= 1'b0;
    end else if (clk_en) begin
      if (preset_we) begin
        carry_r <= preset_carry;
      end else if (exec && kind == K_ADC) begin
        carry_r <= adc_sum[4];
      end else if (exec && kind == K_CAND && !bit_val) begin
        carry_r <= 1'b0;
      end else if (exec && kind == K_COR) begin
        carry_r <= carry_r | bit_val;
      end
    end
  end

  // ==========================================================================
  // Status pulses, one per machine cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      done_r <= 1'b0;
      skip_r <= 1'b0;
      bad_r  <= 1'b0;
    end else if (clk_en) begin
      done_r <= exec && kind != K_NONE;
      skip_r <= exec && (skip_now || discard_imm);
      bad_r  <= exec && kind == K_BAD;
    end
  end

  assign prog_addr            = pc_r;
  assign dm_addr              = dm_addr_r;
  assign dm_we                = dm_we_r;
  assign dm_wdata             = dm_wdata_r;
  assign extended_accumulator = pair_r[PAIR_ACC];
  assign pointer_pair         = pair_r[PAIR_PTR];
  assign pair_wx              = pair_r[PAIR_WX];
  assign pair_yz              = pair_r[PAIR_YZ];
  assign carry                = carry_r;
  assign instr_done           = done_r;
  assign skip_taken           = skip_r;
  assign bad_op               = bad_r;

  // ==========================================================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  and_ptr_a: assert property (exec && kind == K_AND_PTR && !preset_we
    |=> acc == ($past(acc) & $past(dm_rdata))) else $error("AND pointer result wrong");
  and_imm_a: assert property (exec && kind == K_AND_IMM && !preset_we
    |=> acc == ($past(acc) & $past(op2_r[3:0]))) else $error("AND immediate wrong");
  and_pair_a: assert property (exec && kind == K_AND_TO_ACC && !preset_we
    |=> extended_accumulator == ($past(pair_r[PAIR_ACC]) & $past(pair_src)))
    else $error("pair AND into accumulator wrong");
  carry_and_a: assert property (exec && kind == K_CAND && !bit_val && !preset_we
    |=> !carry_r) else $error("carry not cleared by zero bit");
  carry_or_a: assert property (exec && kind == K_COR && !preset_we
    |=> carry_r == ($past(carry_r) | $past(bit_val))) else $error("carry OR wrong");
  bit_clear_a: assert property (exec && kind == K_CLR
    |=> dm_we_r && dm_wdata_r == ($past(dm_rdata) & ~$past(bit_mask)))
    else $error("bit clear write wrong");
  bit_set_a: assert property (exec && kind == K_SET
    |=> dm_we_r && dm_wdata_r == ($past(dm_rdata) | $past(bit_mask)))
    else $error("bit set write wrong");
  skip_zero_a: assert property (exec && kind == K_TEST && !bit_val
    |=> st_r == ST_SKIP1 && skip_r) else $error("zero bit did not skip");
  two_cycle_a: assert property (exec && st_r == ST_FIRST && ir_r == OP_CARRY_AND
    |=> st_r == ST_SECOND) else $error("carry AND not two bytes");
  ovf_inhibit_a: assert property (exec && kind == K_ADD_IMM && after_adc_r && !adc_ovf_r
    |=> st_r == ST_FIRST && !skip_r) else $error("add-skip skipped after add-with-carry");
  adc_skip_a: assert property (exec && kind == K_ADD_IMM && after_adc_r && adc_ovf_r
    && !preset_we |=> skip_r && acc == $past(acc)) else $error("overflow skip missing");
  skip_len_a: assert property (exec && st_r == ST_SKIP1 && skip_len2_r
    |=> st_r == ST_SKIP2 && !dm_we_r) else $error("skip length wrong");
endmodule

// file: hw/logic_bit_pkg.sv
// Constants, opcodes and state types for the logic and bit-operation executor.
// Assumes byte-wide program memory and nibble-wide data memory, both read combinationally.
package logic_bit_pkg;
  localparam logic [7:0]  OP_AND_IMM    = 8'hdd;
  localparam logic [7:0]  OP_PAIR_PFX   = 8'hdc;
  localparam logic [7:0]  OP_AND_PTR    = 8'h39;
  localparam logic [7:0]  OP_ADC_PTR    = 8'h3e;
  localparam logic [7:0]  OP_CARRY_AND  = 8'hf5;
  localparam logic [7:0]  OP_CARRY_OR   = 8'hf6;
  localparam logic [7:0]  OP_TEST_ZERO  = 8'hf8;
  localparam logic [7:0]  OP_BIT_CLR    = 8'hfe;
  localparam logic [7:0]  OP_BIT_SET    = 8'hff;
  localparam logic [3:0]  ADD_SKIP_HI   = 4'ha;
  localparam logic [3:0]  AND_SUBCODE   = 4'h1;
  localparam logic [1:0]  TWO_BYTE_HI   = 2'b11;
  localparam logic [3:0]  DIR_CLR       = 4'h0;
  localparam logic [3:0]  DIR_SET       = 4'h1;
  localparam logic [3:0]  DIR_TEST      = 4'h2;
  localparam logic [1:0]  SB_PAGED      = 2'b00;
  localparam logic [1:0]  SB_SHORT_LO   = 2'b10;
  localparam logic [1:0]  SB_SHORT_HI   = 2'b11;
  localparam logic [1:0]  SB_INDEX_SUB  = 2'b00;
  localparam logic [7:0]  SHORT_LO_PAGE = 8'hfb;
  localparam logic [7:0]  SHORT_HI_PAGE = 8'hff;
  localparam logic [1:0]  INDEX_TOP     = 2'b11;
  localparam logic [3:0]  BANK_ZERO     = 4'h0;
  localparam logic [3:0]  BANK_IO       = 4'hf;
  localparam logic [11:0] PC_RESET      = 12'h000;
  localparam logic [7:0]  PAIR_RESET    = 8'h00;
  localparam logic [1:0]  PAIR_ACC      = 2'h0;
  localparam logic [1:0]  PAIR_PTR      = 2'h1;
  localparam logic [1:0]  PAIR_WX       = 2'h2;
  localparam logic [1:0]  PAIR_YZ       = 2'h3;

  typedef enum logic [1:0] {ST_FIRST, ST_SECOND, ST_SKIP1, ST_SKIP2} seq_state_t;

  typedef enum logic [3:0] {
    K_NONE, K_BAD, K_AND_IMM, K_AND_PTR, K_AND_TO_ACC, K_AND_TO_PAIR,
    K_ADC, K_ADD_IMM, K_CAND, K_COR, K_TEST, K_CLR, K_SET
  } exec_kind_t;
endpackage
